//--- rtl/mst_pkg.sv
package mst_pkg;

  // Register offsets on the 8-bit special function register port
  localparam logic [7:0] OFS_CFG = 8'hC3;
  localparam logic [7:0] OFS_DLT_HI = 8'hA7;
  localparam logic [7:0] OFS_DLT_LO = 8'hA6;
  localparam logic [7:0] OFS_CMP = 8'h94;
  localparam logic [7:0] OFS_OF0 = 8'hA1;
  localparam logic [7:0] OFS_OF1 = 8'hA2;
  localparam logic [7:0] OFS_OF2 = 8'hA3;
  localparam logic [7:0] OFS_CAPL = 8'hA4;
  localparam logic [7:0] OFS_CAPH = 8'hA5;
  localparam logic [7:0] OFS_PEROF0 = 8'h9C;
  localparam logic [7:0] OFS_PEROF1 = 8'h9D;
  localparam logic [7:0] OFS_PEROF2 = 8'h9E;

  // mac_timer_config fields
  localparam int unsigned CFG_CMP_FLAG = 7;
  localparam int unsigned CFG_PER_FLAG = 6;
  localparam int unsigned CFG_OFC_FLAG = 5;
  localparam int unsigned CFG_SEL = 3;
  localparam int unsigned CFG_RSV = 2;
  localparam int unsigned CFG_SYNC = 1;
  localparam int unsigned CFG_RUN = 0;
  localparam logic CFG_SYNC_RESET = 1'b1;

  // overflow_capcmp_top fields
  localparam int unsigned TOP_OFC_MASK = 7;
  localparam int unsigned TOP_CMP_MASK = 6;
  localparam int unsigned TOP_PER_MASK = 5;

  // Synchronous start arithmetic
  localparam int unsigned SYNC_OVERHEAD = 75;
  localparam logic [15:0] RATIO_NUM = 16'h3D09;
  localparam int unsigned RATIO_SHIFT = 4;
  localparam int unsigned DIV_W = 40;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_WAIT = 3'b001,
    ST_CALC = 3'b010,
    ST_RUN = 3'b011,
    ST_STOP_WAIT = 3'b100
  } mst_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mst_bus_req_type;

endpackage : mst_pkg

//--- rtl/mst_mac_symbol_timer.sv
// Operation
// - After reset idle; run bit 1 starts, immediately or on slow edge.
// - Writing run 0 stops, at once or on slow clock edge, except during the start calculation, which ignores it.
// - Counter adds one each cycle while running without delta halt.
// - Next value at or above period overflows, loads next minus period.
// - Overflow sets period flag always; requests interrupt when its mask is 1.
// - Delta write while running freezes counter until delta counts down to zero.
// - Delta counts at timer rate and stays at zero until rewritten.
// - Compare fires when selected byte reaches or passes compare value.
// - Compare sets its flag; requests interrupt when its mask is 1.
// - SFD rising copies timer and overflow count into capture registers.
// - Each overflow adds one to the 20-bit overflow count.
// - Reading low count byte latches upper two bytes; read it first.
// - Lower count bytes held until top byte written; write top last.
// - Count rising to at or above its compare sets flag; interrupt if mask is 1.
// - Flags set by hardware only, cleared by software write only.
// - DMA trigger pulses on each compare and each overflow.
// - Sync start waits slow edge, recalculates, runs 75 cycles after edge.
// - Sync stop runs until slow edge, then halts and stores sleep count.
// - Start value: sleep ticks times 976.5625 plus timer plus 75, divided by period.
// - Period zero is maximum; in low power it forces count values to 0xFFFF.
// - Select 0 compares timer bits 15:8, select 1 bits 7:0.
// - Writing 0 clears a flag, writing 1 leaves it.
// - Run bit reads the real running state.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module mst_mac_symbol_timer #(
  parameter int unsigned SLEEP_W = 24
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire mst_pkg::mst_bus_req_type i_bus,
  output logic [7:0] o_rd_data,
  // Radio, sleep timer and power state
  input wire logic i_sfd_status,
  input wire logic i_slow_clk,
  input wire logic [SLEEP_W-1:0] i_sleep_count,
  input wire logic i_low_power_state,
  // Events
  output logic o_irq_req,
  output logic o_dma_compare_trigger,
  output logic o_dma_overflow_trigger
);

  // Elaboration check: the calculation is sized for a 24-bit sleep timer
  if (SLEEP_W != 24)
  begin : g_bad_sleep_w
    $error("mst_mac_symbol_timer: SLEEP_W must be 24");
  end

  mst_pkg::mst_state_type state, next_state;
  logic [15:0] tmr, next_tmr;
  logic [7:0] tmr_hi_sh, next_tmr_hi_sh;
  logic [7:0] dlt_lo, next_dlt_lo;
  logic [15:0] dlt_cnt, next_dlt_cnt;
  logic [15:0] per, next_per;
  logic [15:0] cap, next_cap;
  logic [7:0] cmpv, next_cmpv;
  logic [19:0] ovf, next_ovf;
  logic [11:0] ovf_sh, next_ovf_sh;
  logic [15:0] ovf_hold, next_ovf_hold;
  logic [19:0] ofc, next_ofc;
  logic [2:0] masks, next_masks;
  logic cmp_flag, next_cmp_flag;
  logic per_flag, next_per_flag;
  logic ofc_flag, next_ofc_flag;
  logic sel, next_sel;
  logic rsv, next_rsv;
  logic sync, next_sync;
  logic ofc_ge, next_ofc_ge;
  logic [SLEEP_W-1:0] stored_sleep, next_stored_sleep;
  logic [6:0] calc_cnt, next_calc_cnt;
  logic [mst_pkg::DIV_W-1:0] dvd, next_dvd;
  logic [16:0] rem, next_rem;
  logic [7:0] next_rd_data;
  logic next_dma_cmp, next_dma_ovf;

  // Synchronisers for the radio SFD status and the slow clock
  logic sfd_s1, sfd_s2, sfd_s3;
  logic slw_s1, slw_s2, slw_s3;
  logic sfd_edge, slow_edge;

  // Scratch values of the next-state logic
  logic [16:0] step, per_eff;
  logic [17:0] div_sh;
  logic [SLEEP_W-1:0] nt;
  logic [SLEEP_W:0] nd;
  logic [mst_pkg::DIV_W-1:0] calc_c;
  logic [7:0] old_b, new_b;
  logic run_now, tick, ovf_evt, cmp_evt, ofc_evt, lp_evt;
  logic wr_cfg, wr_of2, wr_top;

  // Two flops settle the pins; the third only remembers the last level for the edge
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sfd_s1 <= 1'b0;
      sfd_s2 <= 1'b0;
      sfd_s3 <= 1'b0;
      slw_s1 <= 1'b0;
      slw_s2 <= 1'b0;
      slw_s3 <= 1'b0;
    end
    else
    begin
      sfd_s1 <= i_sfd_status;
      sfd_s2 <= sfd_s1;
      sfd_s3 <= sfd_s2;
      slw_s1 <= i_slow_clk;
      slw_s2 <= slw_s1;
      slw_s3 <= slw_s2;
    end
  end

  // One-cycle rising-edge pulses
  assign sfd_edge = sfd_s2 & ~sfd_s3;
  assign slow_edge = slw_s2 & ~slw_s3;

  assign wr_cfg = i_bus.wr && (i_bus.addr == mst_pkg::OFS_CFG);
  assign wr_of2 = i_bus.wr && (i_bus.addr == mst_pkg::OFS_OF2);
  assign wr_top = i_bus.wr && (i_bus.addr == mst_pkg::OFS_PEROF2);
  assign run_now = (state == mst_pkg::ST_RUN) || (state == mst_pkg::ST_STOP_WAIT);

  // Next values of the whole timer
  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    next_tmr_hi_sh = tmr_hi_sh;
    next_dlt_lo = dlt_lo;
    next_dlt_cnt = dlt_cnt;
    next_per = per;
    next_cap = cap;
    next_cmpv = cmpv;
    next_ovf = ovf;
    next_ovf_sh = ovf_sh;
    next_ovf_hold = ovf_hold;
    next_ofc = ofc;
    next_masks = masks;
    next_sel = sel;
    next_rsv = rsv;
    next_sync = sync;
    next_stored_sleep = stored_sleep;
    next_calc_cnt = calc_cnt;
    next_dvd = dvd;
    next_rem = rem;
    next_rd_data = 8'h00;
    lp_evt = 1'b0;
    cmp_evt = 1'b0;
    ovf_evt = 1'b0;
    old_b = 8'h00;
    new_b = 8'h00;
    div_sh = 18'h0_0000;
    // Period zero stands for the full 65536 count
    per_eff = (per == 16'h0000) ? 17'h1_0000 : {1'b0, per};
    step = {1'b0, tmr} + 17'h0_0001;
    tick = run_now && (dlt_cnt == 16'h0000);
    // Sleep ticks since the stop; zero difference means a full wrap
    nt = i_sleep_count - stored_sleep;
    nd = (nt == '0) ? {1'b1, {SLEEP_W{1'b0}}} : {1'b0, nt};
    calc_c = ((mst_pkg::DIV_W'(nd) * mst_pkg::DIV_W'(mst_pkg::RATIO_NUM) + 40'h00_0000_0008)
      >> mst_pkg::RATIO_SHIFT) + mst_pkg::DIV_W'(tmr) + mst_pkg::DIV_W'(mst_pkg::SYNC_OVERHEAD);

    // Counting, overflow and compare
    if (tick)
    begin
      if (step >= per_eff)
      begin
        ovf_evt = 1'b1;
        next_tmr = 16'(step - per_eff);
      end
      else
      begin
        next_tmr = step[15:0];
      end
      old_b = sel ? tmr[7:0] : tmr[15:8];
      new_b = sel ? next_tmr[7:0] : next_tmr[15:8];
      // Fire on crossing only, so a held byte does not retrigger
      cmp_evt = (new_b >= cmpv) && (old_b < cmpv);
    end
    else if (run_now)
    begin
      next_dlt_cnt = dlt_cnt - 16'h0001;
    end
    if (ovf_evt)
    begin
      next_ovf = ovf + 20'h0_0001;
    end

    // Start and stop sequencing
    unique case (state)
      mst_pkg::ST_IDLE:
      begin
        if (wr_cfg && i_bus.wdata[mst_pkg::CFG_RUN])
        begin
          next_state = i_bus.wdata[mst_pkg::CFG_SYNC] ? mst_pkg::ST_START_WAIT : mst_pkg::ST_RUN;
        end
      end
      mst_pkg::ST_START_WAIT:
      begin
        if (wr_cfg && !i_bus.wdata[mst_pkg::CFG_RUN])
        begin
          next_state = mst_pkg::ST_IDLE;
        end
        else if (slow_edge)
        begin
          next_state = mst_pkg::ST_CALC;
          next_calc_cnt = 7'h01;
          next_dvd = calc_c;
          next_rem = 17'h0_0000;
        end
      end
      mst_pkg::ST_CALC:
      begin
        // Restoring divider, one quotient bit per cycle, hidden in the overhead
        next_calc_cnt = calc_cnt + 7'h01;
        if (calc_cnt <= 7'(mst_pkg::DIV_W))
        begin
          div_sh = {rem, dvd[mst_pkg::DIV_W-1]};
          if (div_sh >= {1'b0, per_eff})
          begin
            next_rem = 17'(div_sh - {1'b0, per_eff});
            next_dvd = {dvd[mst_pkg::DIV_W-2:0], 1'b1};
          end
          else
          begin
            next_rem = div_sh[16:0];
            next_dvd = {dvd[mst_pkg::DIV_W-2:0], 1'b0};
          end
        end
        if (calc_cnt == 7'(mst_pkg::SYNC_OVERHEAD - 1))
        begin
          next_state = mst_pkg::ST_RUN;
          if (i_low_power_state && (per == 16'h0000))
          begin
            lp_evt = 1'b1;
            next_tmr = 16'hFFFF;
            next_ovf = 20'h0_FFFF;
          end
          else
          begin
            next_tmr = rem[15:0];
            next_ovf = ovf + dvd[19:0];
          end
        end
      end
      mst_pkg::ST_RUN:
      begin
        if (wr_cfg && !i_bus.wdata[mst_pkg::CFG_RUN])
        begin
          next_state = i_bus.wdata[mst_pkg::CFG_SYNC] ? mst_pkg::ST_STOP_WAIT : mst_pkg::ST_IDLE;
        end
      end
      mst_pkg::ST_STOP_WAIT:
      begin
        if (wr_cfg && i_bus.wdata[mst_pkg::CFG_RUN])
        begin
          next_state = mst_pkg::ST_RUN;
        end
        else if (slow_edge)
        begin
          next_state = mst_pkg::ST_IDLE;
          next_stored_sleep = i_sleep_count;
        end
      end
      default:
      begin
        next_state = mst_pkg::ST_IDLE;
      end
    endcase

    // Register writes
    if (i_bus.wr)
    begin
      unique case (i_bus.addr)
        mst_pkg::OFS_CFG:
        begin
          next_sel = i_bus.wdata[mst_pkg::CFG_SEL];
          next_rsv = i_bus.wdata[mst_pkg::CFG_RSV];
          next_sync = i_bus.wdata[mst_pkg::CFG_SYNC];
        end
        mst_pkg::OFS_DLT_LO:
        begin
          next_dlt_lo = i_bus.wdata;
          if (!run_now)
          begin
            next_tmr[7:0] = i_bus.wdata;
          end
        end
        mst_pkg::OFS_DLT_HI:
        begin
          if (run_now)
          begin
            next_dlt_cnt = {i_bus.wdata, dlt_lo};
          end
          else
          begin
            next_tmr[15:8] = i_bus.wdata;
          end
        end
        mst_pkg::OFS_CMP: next_cmpv = i_bus.wdata;
        mst_pkg::OFS_OF0: next_ovf_hold[7:0] = i_bus.wdata;
        mst_pkg::OFS_OF1: next_ovf_hold[15:8] = i_bus.wdata;
        mst_pkg::OFS_OF2: next_ovf = {i_bus.wdata[3:0], ovf_hold};
        mst_pkg::OFS_CAPL: next_per[7:0] = i_bus.wdata;
        mst_pkg::OFS_CAPH: next_per[15:8] = i_bus.wdata;
        mst_pkg::OFS_PEROF0: next_ofc[7:0] = i_bus.wdata;
        mst_pkg::OFS_PEROF1: next_ofc[15:8] = i_bus.wdata;
        mst_pkg::OFS_PEROF2:
        begin
          next_ofc[19:16] = i_bus.wdata[3:0];
          // A coinciding capture drops the three upper bits of this write
          if (!sfd_edge)
          begin
            next_masks = i_bus.wdata[7:5];
          end
        end
        default:
        begin
        end
      endcase
    end

    // SFD capture overrides software writes to the same registers
    if (sfd_edge)
    begin
      next_cap = tmr;
      next_ofc = ovf;
    end

    // Reads answer in the next cycle; the low bytes latch the upper ones
    if (i_bus.rd)
    begin
      unique case (i_bus.addr)
        mst_pkg::OFS_CFG:
          next_rd_data = {cmp_flag, per_flag, ofc_flag, 1'b0, sel, rsv, sync, run_now};
        mst_pkg::OFS_DLT_LO:
        begin
          next_rd_data = tmr[7:0];
          next_tmr_hi_sh = tmr[15:8];
        end
        mst_pkg::OFS_DLT_HI: next_rd_data = tmr_hi_sh;
        mst_pkg::OFS_CMP: next_rd_data = cmpv;
        mst_pkg::OFS_OF0:
        begin
          next_rd_data = ovf[7:0];
          next_ovf_sh = ovf[19:8];
        end
        mst_pkg::OFS_OF1: next_rd_data = ovf_sh[7:0];
        mst_pkg::OFS_OF2: next_rd_data = {4'h0, ovf_sh[11:8]};
        mst_pkg::OFS_CAPL: next_rd_data = cap[7:0];
        mst_pkg::OFS_CAPH: next_rd_data = cap[15:8];
        mst_pkg::OFS_PEROF0: next_rd_data = ofc[7:0];
        mst_pkg::OFS_PEROF1: next_rd_data = ofc[15:8];
        mst_pkg::OFS_PEROF2: next_rd_data = {masks, 1'b0, ofc[19:16]};
        default: next_rd_data = 8'h00;
      endcase
    end

    // Overflow count compare on the rising of the at-or-above condition
    next_ofc_ge = (ovf >= ofc);
    ofc_evt = next_ofc_ge && !ofc_ge;

    // Flags: hardware set wins over a software clear in the same cycle
    next_cmp_flag = cmp_evt || (cmp_flag && !(wr_cfg && !i_bus.wdata[mst_pkg::CFG_CMP_FLAG]));
    next_per_flag = ovf_evt || lp_evt || (per_flag && !(wr_cfg && !i_bus.wdata[mst_pkg::CFG_PER_FLAG]));
    next_ofc_flag = ofc_evt || (ofc_flag && !(wr_cfg && !i_bus.wdata[mst_pkg::CFG_OFC_FLAG]));
    next_dma_cmp = cmp_evt;
    next_dma_ovf = ovf_evt || lp_evt;
  end

  // Timer state registers
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= mst_pkg::ST_IDLE;
      tmr <= 16'h0000;
      tmr_hi_sh <= 8'h00;
      dlt_lo <= 8'h00;
      dlt_cnt <= 16'h0000;
      per <= 16'h0000;
      cap <= 16'h0000;
      cmpv <= 8'h00;
      ovf <= 20'h0_0000;
      ovf_sh <= 12'h000;
      ovf_hold <= 16'h0000;
      ofc <= 20'h0_0000;
      masks <= 3'h0;
      cmp_flag <= 1'b0;
      per_flag <= 1'b0;
      ofc_flag <= 1'b0;
      sel <= 1'b0;
      rsv <= 1'b0;
      sync <= mst_pkg::CFG_SYNC_RESET;
      ofc_ge <= 1'b1;
      stored_sleep <= '0;
      calc_cnt <= 7'h00;
      dvd <= '0;
      rem <= 17'h0_0000;
      o_rd_data <= 8'h00;
      o_dma_compare_trigger <= 1'b0;
      o_dma_overflow_trigger <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      tmr_hi_sh <= next_tmr_hi_sh;
      dlt_lo <= next_dlt_lo;
      dlt_cnt <= next_dlt_cnt;
      per <= next_per;
      cap <= next_cap;
      cmpv <= next_cmpv;
      ovf <= next_ovf;
      ovf_sh <= next_ovf_sh;
      ovf_hold <= next_ovf_hold;
      ofc <= next_ofc;
      masks <= next_masks;
      cmp_flag <= next_cmp_flag;
      per_flag <= next_per_flag;
      ofc_flag <= next_ofc_flag;
      sel <= next_sel;
      rsv <= next_rsv;
      sync <= next_sync;
      ofc_ge <= next_ofc_ge;
      stored_sleep <= next_stored_sleep;
      calc_cnt <= next_calc_cnt;
      dvd <= next_dvd;
      rem <= next_rem;
      o_rd_data <= next_rd_data;
      o_dma_compare_trigger <= next_dma_cmp;
      o_dma_overflow_trigger <= next_dma_ovf;
    end
  end

  // Interrupt request, a level while any unmasked flag stands
  assign o_irq_req = (per_flag && masks[mst_pkg::TOP_PER_MASK - 5]) ||
    (cmp_flag && masks[mst_pkg::TOP_CMP_MASK - 5]) ||
    (ofc_flag && masks[mst_pkg::TOP_OFC_MASK - 5]);

  a_run_immediate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state == mst_pkg::ST_IDLE && wr_cfg && !i_bus.wdata[mst_pkg::CFG_SYNC] && i_bus.wdata[mst_pkg::CFG_RUN])
    |=> (state == mst_pkg::ST_RUN))
    else $error("immediate start did not enter run");

  a_stop_immediate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state == mst_pkg::ST_RUN && wr_cfg && !i_bus.wdata[mst_pkg::CFG_SYNC] && !i_bus.wdata[mst_pkg::CFG_RUN])
    |=> (state == mst_pkg::ST_IDLE))
    else $error("immediate stop did not enter idle");

  a_count_step: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state == mst_pkg::ST_RUN && dlt_cnt == 16'h0000 && !ovf_evt) |=> (tmr == $past(tmr) + 16'h0001))
    else $error("timer did not advance by one");

  a_overflow_wrap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ovf_evt |=> (tmr == 16'($past(step) - $past(per_eff))))
    else $error("overflow did not load next minus period");

  a_period_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ovf_evt |=> (per_flag && o_dma_overflow_trigger))
    else $error("overflow flag or trigger missing");

  a_delta_freeze: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (run_now && dlt_cnt != 16'h0000) |=> $stable(tmr))
    else $error("timer moved during delta halt");

  a_ovf_count: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (ovf_evt && !wr_of2) |=> (ovf == $past(ovf) + 20'h0_0001))
    else $error("overflow count did not increment");

  a_sync_start: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state == mst_pkg::ST_START_WAIT && slow_edge && !wr_cfg) |-> ##75 (state == mst_pkg::ST_RUN))
    else $error("synchronous start not 75 cycles after edge");

  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (wr_cfg && i_bus.wdata[mst_pkg::CFG_CMP_FLAG] && cmp_flag) |=> cmp_flag)
    else $error("writing one cleared the compare flag");

  a_cmp_event: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    cmp_evt |=> (cmp_flag && o_dma_compare_trigger))
    else $error("compare flag or trigger missing");

  a_sfd_capture: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    sfd_edge |=> (cap == $past(tmr) && ofc == $past(ovf)))
    else $error("capture did not take timer and count");

  a_count_latch: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_bus.rd && i_bus.addr == mst_pkg::OFS_OF0) |=> (ovf_sh == $past(ovf[19:8])))
    else $error("upper count bytes not latched");

endmodule : mst_mac_symbol_timer

`default_nettype wire

//--- bench/mst_sleep_model.sv
`timescale 1ns/1ps
`default_nettype none

module mst_sleep_model #(
  parameter int unsigned HALF = 488
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Sleep timer side
  output logic o_slow_clk,
  output logic [23:0] o_sleep_count
);
  int unsigned div;

  // Slow clock runs free at the 32 MHz ratio; tick count steps on its rising edge
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      div <= 0;
      o_slow_clk <= 1'b0;
      o_sleep_count <= 24'h00_0000;
    end
    else if (div == HALF - 1)
    begin
      div <= 0;
      o_slow_clk <= ~o_slow_clk;
      if (!o_slow_clk)
        o_sleep_count <= o_sleep_count + 24'h00_0001;
    end
    else
      div <= div + 1;
  end
endmodule : mst_sleep_model

`default_nettype wire

//--- bench/mac_symbol_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mac_symbol_timer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sfd = 1'b0;
  logic lp = 1'b0;
  longint c;
  logic slow;
  logic irq;
  logic dma_cmp;
  logic dma_ovf;
  logic [23:0] sleep;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [7:0] tl;
  logic [7:0] th;
  logic [19:0] cnt;
  mst_pkg::mst_bus_req_type bus = '0;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n = 0;
  int ovf_n = 0;
  int ovf_t = 0;
  int ovf_gap = 0;
  int cmp_gap = 0;
  // Rows: address, write data, expected read back
  logic [7:0] rows [5][3] = '{'{mst_pkg::OFS_CMP, 8'h5A, 8'h5A}, '{mst_pkg::OFS_PEROF0, 8'h12, 8'h12},
    '{mst_pkg::OFS_PEROF1, 8'h34, 8'h34}, '{mst_pkg::OFS_CFG, 8'h08, 8'h08}, '{8'h00, 8'hFF, 8'h00}};

  // Clock
  always #4 clk = ~clk;

  mst_mac_symbol_timer dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rd_data(rdata),
    .i_sfd_status(sfd), .i_slow_clk(slow), .i_sleep_count(sleep), .i_low_power_state(lp),
    .o_irq_req(irq), .o_dma_compare_trigger(dma_cmp), .o_dma_overflow_trigger(dma_ovf));

  mst_sleep_model sleep_u (.i_sys_clk(clk), .i_sys_rst(rst), .o_slow_clk(slow), .o_sleep_count(sleep));

  // Event spacing in cycles; the ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (dma_ovf === 1'b1)
    begin
      ovf_n <= ovf_n + 1;
      ovf_gap <= cyc - ovf_t;
      ovf_t <= cyc;
    end
    if (dma_cmp === 1'b1)
      cmp_gap <= cyc - ovf_t;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // Bus cycles: one strobe cycle, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'h02, "config reset");
    foreach (rows[i])
    begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], d);
      chk8(d, rows[i][2], "readback");
    end
    // Period 16, idle timer load, compare on the low byte
    wr(mst_pkg::OFS_CAPL, 8'h10);
    wr(mst_pkg::OFS_CAPH, 8'h00);
    wr(mst_pkg::OFS_DLT_LO, 8'h0E);
    wr(mst_pkg::OFS_DLT_HI, 8'h00);
    wr(mst_pkg::OFS_CMP, 8'h08);
    rd(mst_pkg::OFS_DLT_LO, d);
    chk8(d, 8'h0E, "idle load");
    wr(mst_pkg::OFS_CFG, 8'h09);
    repeat (100) @(posedge clk);
    chk8(ovf_gap[7:0], 8'h10, "period");
    chk8(cmp_gap[7:0], 8'h08, "compare");
    chk8({7'h00, irq}, 8'h00, "masked irq");
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'hC9, "flags");
    // Delta written just after an overflow stretches one period only
    n = ovf_n;
    while (ovf_n == n)
      @(posedge clk);
    wr(mst_pkg::OFS_DLT_LO, 8'h05);
    wr(mst_pkg::OFS_DLT_HI, 8'h00);
    repeat (24) @(posedge clk);
    chk8(ovf_gap[7:0], 8'h15, "delta");
    repeat (20) @(posedge clk);
    chk8(ovf_gap[7:0], 8'h10, "delta once");
    wr(mst_pkg::OFS_PEROF2, 8'h20);
    @(posedge clk);
    #1 chk8({7'h00, irq}, 8'h01, "unmasked irq");
    // Immediate stop, low byte first
    wr(mst_pkg::OFS_CFG, 8'hE8);
    repeat (4) @(posedge clk);
    cnt = 20'(ovf_n);
    rd(mst_pkg::OFS_OF0, d);
    chk8(d, cnt[7:0], "count low");
    rd(mst_pkg::OFS_OF1, d);
    chk8(d, cnt[15:8], "count mid");
    rd(mst_pkg::OFS_OF2, d);
    chk8(d, {4'h0, cnt[19:16]}, "count top");
    rd(mst_pkg::OFS_DLT_LO, tl);
    rd(mst_pkg::OFS_DLT_HI, th);
    repeat (10) @(posedge clk);
    rd(mst_pkg::OFS_DLT_LO, d);
    chk8(d, tl, "stopped");
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'hC8, "flags kept");
    wr(mst_pkg::OFS_CFG, 8'h28);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'h08, "flags cleared");
    chk8({7'h00, irq}, 8'h00, "irq cleared");
    // Count load in idle: lower bytes wait for the top byte
    wr(mst_pkg::OFS_OF0, 8'hC7);
    wr(mst_pkg::OFS_OF1, 8'hA3);
    rd(mst_pkg::OFS_OF0, d);
    chk8(d, cnt[7:0], "count held");
    cnt = 20'h5_A3C7;
    wr(mst_pkg::OFS_OF2, 8'h05);
    rd(mst_pkg::OFS_OF0, d);
    chk8(d, cnt[7:0], "count load low");
    rd(mst_pkg::OFS_OF1, d);
    chk8(d, cnt[15:8], "count load mid");
    // Frame delimiter capture of a frozen timer
    @(posedge clk);
    sfd <= 1'b1;
    repeat (8) @(posedge clk);
    sfd <= 1'b0;
    rd(mst_pkg::OFS_CAPL, d);
    chk8(d, tl, "capture low");
    rd(mst_pkg::OFS_CAPH, d);
    chk8(d, th, "capture high");
    rd(mst_pkg::OFS_PEROF0, d);
    chk8(d, cnt[7:0], "capture count");
    // Count compare three overflows ahead, only its mask set
    cnt = cnt + 20'h0_0003;
    wr(mst_pkg::OFS_PEROF0, cnt[7:0]);
    wr(mst_pkg::OFS_PEROF1, cnt[15:8]);
    wr(mst_pkg::OFS_PEROF2, {4'h8, cnt[19:16]});
    rd(mst_pkg::OFS_PEROF2, d);
    chk8(d, {4'h8, cnt[19:16]}, "mask readback");
    wr(mst_pkg::OFS_CFG, 8'h09);
    repeat (100) @(posedge clk);
    wr(mst_pkg::OFS_CFG, 8'hE8);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'hE8, "count compare");
    chk8({7'h00, irq}, 8'h01, "count irq");
    rd(mst_pkg::OFS_DLT_LO, tl);
    rd(mst_pkg::OFS_DLT_HI, th);
    // Synchronised start and stop against the slow edge
    wr(mst_pkg::OFS_CFG, 8'h08);
    @(negedge slow);
    wr(mst_pkg::OFS_CFG, 8'h0B);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d, 8'h0A, "start wait");
    @(posedge slow);
    repeat (40) @(posedge clk);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d & 8'h01, 8'h00, "calc");
    repeat (45) @(posedge clk);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d & 8'h01, 8'h01, "sync run");
    // Loaded 75 cycles after the edge, then 13 more ticks before this read
    c = ((longint'(sleep) * 15625 + 8) >> 4) + longint'({th, tl}) + 75 + 13;
    rd(mst_pkg::OFS_DLT_LO, d);
    chk8(d, 8'(c % 16), "sync value");
    @(negedge slow);
    wr(mst_pkg::OFS_CFG, 8'h0A);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d & 8'h01, 8'h01, "stop wait");
    @(posedge slow);
    repeat (10) @(posedge clk);
    rd(mst_pkg::OFS_CFG, d);
    chk8(d & 8'h01, 8'h00, "sync stop");
    // Period zero in low power forces the count to 0xFFFF, then one overflow
    wr(mst_pkg::OFS_CAPL, 8'h00);
    lp <= 1'b1;
    wr(mst_pkg::OFS_CAPH, 8'h00);
    wr(mst_pkg::OFS_CFG, 8'h0B);
    @(posedge slow);
    repeat (80) @(posedge clk);
    rd(mst_pkg::OFS_OF0, d);
    chk8(d, 8'h00, "low power low");
    rd(mst_pkg::OFS_OF2, d);
    chk8(d, 8'h01, "low power top");
    print_verdict();
  end
endmodule : mac_symbol_timer_tb

`default_nettype wire
